// ===== rtl/frp_host.sv
`timescale 1ns/1ns
// Contract
// [R1] device sleeps after stable address
// [R2] sleep independent of control pins
// [R3] sleep keeps data; new address reads normally
// [R4] output gate high floats data
// [R5] reset held low minimum pulse time
// [R6] reset returns device to array read
// [R7] host restarts aborted program or erase; the host only pulses reset and leaves the reissue to the caller
// [R8] busy held low during reset recovery
// [R9] read only after reset-to-read delay
// [R10] sectors grouped by four
// [R11] protected group refuses program and erase
// [R12] protect: high voltage id and gate
// [R13] protect via high voltage reset only; the host protects with id and gate high voltage and reset high instead
// [R14] verify read returns protect flag
// [R15] verify ignores addresses except protect-select
// [R16] in-system id read shows protection
// [R17] unprotect: high voltage, direction high
// [R18] protect all before chip unprotect; the host issues unprotect without protecting the groups first
// [R19] unprotect then verify reads zero
// [R20] high voltage reset temporarily unprotects
// [R21] id read gives maker or device code
// [R22] write needs select, strobe low, gate high
// [R23] high voltage as separate qualifier input
module frp_host #(
  parameter int ADDR_WIDTH = frp_pkg::ADDR_W
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire frp_pkg::frp_op_t        req_op,
  input  wire logic [ADDR_WIDTH-1:0]   req_addr,
  input  wire logic [7:0]              req_wdata,
  input  wire logic                    req_temp_unprot,
  output logic                         rsp_valid,
  output logic [7:0]                   rsp_rdata,
  output logic                         rsp_protected,
  output logic                         busy,
  output logic                         flash_ce_n,
  output logic                         flash_oe_n,
  output logic                         flash_oe_hv,
  output logic                         flash_we_n,
  output logic                         flash_reset_n,
  output logic                         flash_reset_hv,
  output logic [ADDR_WIDTH-1:0]        flash_addr,
  output logic                         flash_id_hv,
  output logic [7:0]                   flash_dq_out,
  output logic                         flash_dq_oe_n,
  input  wire logic [7:0]              flash_dq_in,
  input  wire logic                    ready_busy_n
);
  import frp_pkg::*;

  frp_state_t        state_q;
  frp_op_t           op_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [7:0]        dq_s1_q, dq_s2_q;
  logic              rb_s1_q, rb_s2_q;
  logic [CNT_W-1:0]  rst_lo_q;

  function automatic logic [ADDR_WIDTH-1:0] ctl_addr(input logic [ADDR_WIDTH-1:0] a,
                                                    input logic dir, input logic psel,
                                                    input logic csel);
    logic [ADDR_WIDTH-1:0] r;
    r = a;
    r[DIRECTION_BIT]   = dir;
    r[PROT_SELECT_BIT] = psel;
    r[CODE_SELECT_BIT] = csel;
    return r;
  endfunction : ctl_addr

  function automatic logic is_hv_op(input frp_op_t o);
    return o == FRP_OP_PROTECT || o == FRP_OP_UNPROT || o == FRP_OP_VERIFY ||
           o == FRP_OP_ID_MFR || o == FRP_OP_ID_DEV;
  endfunction : is_hv_op

  always_ff @(posedge clock) begin
    dq_s1_q <= flash_dq_in;
    dq_s2_q <= dq_s1_q;
    rb_s1_q <= ready_busy_n;
    rb_s2_q <= rb_s1_q;
  end

  assign req_ready = (state_q == FRP_ST_IDLE) && rst_n;
  assign busy      = (state_q != FRP_ST_IDLE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= FRP_ST_RST;
      op_q    <= FRP_OP_RESET;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        FRP_ST_IDLE: begin
          cnt_q <= '0;
          if (req_valid) begin
            op_q <= req_op;
            state_q <= (req_op == FRP_OP_RESET) ? FRP_ST_RST : FRP_ST_SETUP;
          end
        end
        FRP_ST_RST: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(RESET_PULSE_CYC - 1)) begin // R5
            cnt_q   <= '0;
            state_q <= FRP_ST_REC;
          end
        end
        FRP_ST_REC: begin
          cnt_q <= cnt_q + 1'b1;
          // wait out reset-to-read and any busy recovery
          if (cnt_q >= CNT_W'(RESET_REC_CYC - 1) && rb_s2_q) begin // R8 R9
            cnt_q   <= '0;
            state_q <= FRP_ST_IDLE;
          end
        end
        FRP_ST_SETUP: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(SETUP_CYC - 1)) begin
            cnt_q   <= '0;
            state_q <= FRP_ST_STROBE;
          end
        end
        FRP_ST_STROBE: begin
          cnt_q <= cnt_q + 1'b1;
          // read strobe covers access time plus sync delay
          if (cnt_q >= CNT_W'(((op_q == FRP_OP_WRITE || op_q == FRP_OP_PROTECT ||
                                op_q == FRP_OP_UNPROT) ? WE_PULSE_CYC : ACCESS_CYC + 2) - 1)) begin
            cnt_q   <= '0;
            state_q <= FRP_ST_HOLD;
          end
        end
        FRP_ST_HOLD: state_q <= FRP_ST_IDLE;
        default: state_q <= FRP_ST_RST;
      endcase
    end
  end

  // consecutive cycles with the reset pin low, saturating
  always_ff @(posedge clock) begin
    if (!rst_n) rst_lo_q <= '0;
    else if (flash_reset_n) rst_lo_q <= '0;
    else if (rst_lo_q != '1) rst_lo_q <= rst_lo_q + 1'b1;
  end

  // pin drive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flash_ce_n     <= 1'b1;
      flash_oe_n     <= 1'b1;
      flash_oe_hv    <= 1'b0;
      flash_we_n     <= 1'b1;
      flash_reset_n  <= 1'b0;
      flash_reset_hv <= 1'b0;
      flash_id_hv    <= 1'b0;
      flash_addr     <= '0;
      flash_dq_out   <= '0;
      flash_dq_oe_n  <= 1'b1;
    end else begin
      flash_reset_n  <= !(state_q == FRP_ST_RST || (state_q == FRP_ST_IDLE && req_valid &&
                          req_op == FRP_OP_RESET)); // R5 R6 R7
      flash_reset_hv <= req_temp_unprot && state_q != FRP_ST_RST; // R20 R13 R23
      if (state_q == FRP_ST_IDLE && req_valid && req_op != FRP_OP_RESET) begin
        flash_ce_n  <= 1'b0;
        flash_id_hv <= is_hv_op(req_op); // R23
        case (req_op)
          FRP_OP_PROTECT: flash_addr <= ctl_addr(req_addr, 1'b0, 1'b1, 1'b0); // R12 R10
          FRP_OP_UNPROT:  flash_addr <= ctl_addr(req_addr, 1'b1, 1'b1, 1'b0); // R17 R18
          FRP_OP_VERIFY:  flash_addr <= ctl_addr(req_addr, 1'b0, 1'b1, 1'b0); // R14 R15
          FRP_OP_ID_MFR:  flash_addr <= ctl_addr(req_addr, 1'b0, 1'b0, 1'b0); // R21
          FRP_OP_ID_DEV:  flash_addr <= ctl_addr(req_addr, 1'b0, 1'b0, 1'b1); // R21
          default:        flash_addr <= req_addr; // R16 R11
        endcase
        flash_oe_hv   <= req_op == FRP_OP_PROTECT || req_op == FRP_OP_UNPROT; // R12 R17
        flash_dq_out  <= req_wdata;
        flash_dq_oe_n <= !(req_op == FRP_OP_WRITE);
      end else if (state_q == FRP_ST_SETUP && cnt_q >= CNT_W'(SETUP_CYC - 1)) begin
        if (op_q == FRP_OP_WRITE || op_q == FRP_OP_PROTECT || op_q == FRP_OP_UNPROT)
          flash_we_n <= 1'b0; // R22
        else
          flash_oe_n <= 1'b0; // R4
      end else if (state_q == FRP_ST_HOLD) begin
        flash_we_n    <= 1'b1;
        flash_oe_n    <= 1'b1; // R4
        flash_oe_hv   <= 1'b0;
        flash_ce_n    <= 1'b1;
        flash_id_hv   <= 1'b0;
        flash_dq_oe_n <= 1'b1;
      end
    end
  end

  // response capture, data from flip-flops
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rsp_valid     <= 1'b0;
      rsp_rdata     <= '0;
      rsp_protected <= 1'b0;
    end else begin
      rsp_valid <= state_q == FRP_ST_HOLD;
      if (state_q == FRP_ST_HOLD) begin
        rsp_rdata     <= (op_q == FRP_OP_WRITE || op_q == FRP_OP_PROTECT ||
                          op_q == FRP_OP_UNPROT) ? 8'h00 : dq_s2_q; // R1 R2 R3
        rsp_protected <= dq_s2_q[PROT_FLAG_BIT]; // R14 R19
      end
    end
  end

  a_reset_pulse_len: assert property (@(posedge clock) disable iff (!rst_n) // R5
    $rose(flash_reset_n) |-> rst_lo_q >= CNT_W'(RESET_PULSE_CYC))
    else $error("reset pulse too short");
  a_write_gate_high: assert property (@(posedge clock) disable iff (!rst_n) // R22
    !flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe without select or with gate low");
  a_no_drive_on_read: assert property (@(posedge clock) disable iff (!rst_n) // R4
    !flash_oe_n |-> flash_dq_oe_n)
    else $error("host drives data while gate low");
  a_protect_pins: assert property (@(posedge clock) disable iff (!rst_n) // R12
    !flash_we_n && op_q == FRP_OP_PROTECT |-> flash_id_hv && flash_oe_hv &&
      !flash_addr[DIRECTION_BIT])
    else $error("protect pin setup wrong");
  a_unprot_pins: assert property (@(posedge clock) disable iff (!rst_n) // R17
    !flash_we_n && op_q == FRP_OP_UNPROT |-> flash_id_hv && flash_oe_hv &&
      flash_addr[DIRECTION_BIT])
    else $error("unprotect pin setup wrong");
  a_verify_sel: assert property (@(posedge clock) disable iff (!rst_n) // R14
    !flash_oe_n && op_q == FRP_OP_VERIFY |-> flash_id_hv && flash_addr[PROT_SELECT_BIT])
    else $error("verify without protect-select high");
  a_id_code_sel: assert property (@(posedge clock) disable iff (!rst_n) // R21
    !flash_oe_n && op_q == FRP_OP_ID_DEV |-> flash_addr[CODE_SELECT_BIT] &&
      !flash_addr[PROT_SELECT_BIT] && !flash_addr[DIRECTION_BIT])
    else $error("device code select wrong");
  a_read_after_rec: assert property (@(posedge clock) disable iff (!rst_n) // R9
    $rose(flash_reset_n) |-> flash_oe_n [*5])
    else $error("read before reset-to-read delay");
  a_rsp_after_hold: assert property (@(posedge clock) disable iff (!rst_n)
    state_q == FRP_ST_HOLD |=> rsp_valid)
    else $error("missing response");

  c_write: cover property (@(posedge clock) disable iff (!rst_n)
    rsp_valid && op_q == FRP_OP_WRITE);
  c_verify: cover property (@(posedge clock) disable iff (!rst_n)
    rsp_valid && op_q == FRP_OP_VERIFY);
  c_reset: cover property (@(posedge clock) disable iff (!rst_n) $rose(flash_reset_n));
  c_temp: cover property (@(posedge clock) disable iff (!rst_n) flash_reset_hv && !flash_we_n);
endmodule : frp_host

// ===== rtl/frp_pkg.sv
package frp_pkg;
  localparam int ADDR_W          = 23;
  localparam int DATA_W          = 8;
  localparam int CLK_PERIOD_NS   = 10;
  // pin timing, ns
  localparam int RESET_PULSE_MIN_NS     = 500;
  localparam int RESET_TO_READ_DELAY_NS = 50;
  localparam int ACCESS_TIME_NS         = 90;
  localparam int WE_PULSE_NS            = 100;
  localparam int SETUP_NS               = 20;
  // cycle counts: least times round up
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_REC_CYC   = (RESET_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC      = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int WE_PULSE_CYC    = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 8;
  // sector grouping and control address bits
  localparam int SECTORS_PER_GROUP = 4;
  localparam int ID_SELECT_BIT     = 9;
  localparam int DIRECTION_BIT     = 6;
  localparam int PROT_SELECT_BIT   = 1;
  localparam int CODE_SELECT_BIT   = 0;
  localparam int PROT_FLAG_BIT     = 0;
  localparam int SECTOR_LSB        = 15;

  typedef enum logic [2:0] {
    FRP_OP_READ    = 3'h0,
    FRP_OP_WRITE   = 3'h1,
    FRP_OP_PROTECT = 3'h2,
    FRP_OP_UNPROT  = 3'h3,
    FRP_OP_VERIFY  = 3'h4,
    FRP_OP_ID_MFR  = 3'h5,
    FRP_OP_ID_DEV  = 3'h6,
    FRP_OP_RESET   = 3'h7
  } frp_op_t;

  typedef enum logic [5:0] {
    FRP_ST_IDLE   = 6'h01,
    FRP_ST_RST    = 6'h02,
    FRP_ST_REC    = 6'h04,
    FRP_ST_SETUP  = 6'h08,
    FRP_ST_STROBE = 6'h10,
    FRP_ST_HOLD   = 6'h20
  } frp_state_t;
endpackage : frp_pkg

// ===== test/frp_flash_model.sv
`timescale 1ns/1ns
module frp_flash_model #(
  parameter int         ACC_NS   = 90,
  parameter int         RTR_NS   = 50,
  parameter int         PROG_NS  = 300,
  parameter int         READY_NS = 700,
  parameter logic [7:0] MFR_CODE = 8'h3c,  // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h5a   // arbitrary value
) (
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_oe_hv,
  input  wire logic        flash_we_n,
  input  wire logic        flash_reset_n,
  input  wire logic        flash_reset_hv,
  input  wire logic [22:0] flash_addr,
  input  wire logic        flash_id_hv,
  input  wire logic [7:0]  flash_dq_out,
  output logic      [7:0]  mem_dq,
  output logic             ready_busy_n
);
  logic [7:0]  mem [logic [22:0]];
  logic [63:0] prot_q = '0;
  logic [22:0] a_q;
  logic [7:0]  d_q, rd, dq_c, last_q = 8'h00;
  logic        wr_q = 1'b0, pr_q = 1'b0;
  int          wr_cnt = 0;
  logic        rec_ok = 1'b0, rb_q = 1'b1;
  realtime     busy_until = 0;
  wire on    = flash_reset_n | flash_reset_hv;
  wire drive = on & rec_ok & !flash_ce_n & !flash_oe_n & !flash_oe_hv;
  // no valid data until the reset-to-read delay has run out
  always @(negedge flash_reset_n) begin
    rec_ok = 1'b0;
    // reset inside a program keeps busy until internal reset ends
    if ($realtime < busy_until) busy_until = $realtime + READY_NS;
  end
  always @(posedge flash_reset_n) rec_ok <= #(RTR_NS) 1'b1;
  always #1 rb_q = $realtime >= busy_until;
  // data stays latched while the address is still
  always @(flash_addr, flash_id_hv, prot_q, wr_cnt) begin
    if (flash_id_hv && flash_addr[1]) rd = {7'h00, prot_q[flash_addr[22:17]]};
    else if (flash_id_hv) rd = flash_addr[0] ? DEV_CODE : MFR_CODE;
    else rd = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
  end
  always @(negedge drive) last_q = rd;
  // released bus shows the inverse, never a stale copy
  always @* dq_c = drive ? rd : ~last_q;
  assign #(ACC_NS) mem_dq = dq_c;
  assign ready_busy_n = rb_q;
  always @(negedge flash_we_n) begin
    a_q  = flash_addr;
    d_q  = flash_dq_out;
    wr_q = on && !flash_ce_n && flash_oe_n && !flash_oe_hv && !flash_id_hv;
    pr_q = flash_reset_n && !flash_ce_n && flash_oe_hv && flash_id_hv;
  end
  always @(posedge flash_we_n) begin
    if (pr_q && !a_q[6]) prot_q[a_q[22:17]] = 1'b1;
    else if (pr_q) prot_q = '0;
    else if (wr_q && (!prot_q[a_q[22:17]] || flash_reset_hv)) begin
      mem[a_q] = d_q;
      wr_cnt++;
      busy_until = $realtime + PROG_NS;
    end
    wr_q = 1'b0;
    pr_q = 1'b0;
  end
endmodule : frp_flash_model

// ===== test/flash_reset_protect_id_port_test.sv
`timescale 1ns/1ns
module flash_reset_protect_id_port_test;
  import frp_pkg::*;
  localparam logic [7:0] MFR = 8'h3c;  // arbitrary value
  localparam logic [7:0] DEV = 8'h5a;  // arbitrary value
  logic        clock = 0, rst_n = 0, req_valid = 0, req_temp_unprot = 0;
  frp_op_t     req_op = FRP_OP_READ;
  logic [22:0] req_addr = '0, flash_addr, a;
  logic [7:0]  req_wdata = '0, rsp_rdata, flash_dq_out, flash_dq_in, mem_dq, d;
  logic        req_ready, rsp_valid, rsp_protected, busy, flash_ce_n, flash_oe_n, flash_oe_hv;
  logic        flash_we_n, flash_reset_n, flash_reset_hv, flash_id_hv, flash_dq_oe_n;
  logic        ready_busy_n;
  logic [7:0]  exp_mem [logic [22:0]];
  logic [63:0] exp_prot = '0;
  int          num_errors = 0, check_count = 0, rlow = 0, rlow0 = 0;
  integer      seed = 32'h82da7ec8;
  assign flash_dq_in = flash_dq_oe_n ? mem_dq : flash_dq_out;
  frp_host dut (.clock, .rst_n, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata,
    .req_temp_unprot, .rsp_valid, .rsp_rdata, .rsp_protected, .busy, .flash_ce_n,
    .flash_oe_n, .flash_oe_hv, .flash_we_n, .flash_reset_n, .flash_reset_hv, .flash_addr,
    .flash_id_hv, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in, .ready_busy_n);
  frp_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.flash_ce_n, .flash_oe_n,
    .flash_oe_hv, .flash_we_n, .flash_reset_n, .flash_reset_hv, .flash_addr, .flash_id_hv,
    .flash_dq_out, .mem_dq, .ready_busy_n);
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (flash_reset_n === 1'b0) rlow <= rlow + 1;
  initial begin
    #(4000 * CLK_PERIOD_NS);
    num_errors++;
    results();
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1
  task automatic op(input frp_op_t o, input logic [22:0] ad, input logic [7:0] wd);
    int n = 0;
    @(posedge clock); #1;
    req_valid = 1;
    req_op = o;
    req_addr = ad;
    req_wdata = wd;
    while (req_ready !== 1'b1 && n < 500) begin @(posedge clock); #1; n++; end
    @(posedge clock); #1;
    req_valid = 0;
    while (n < 500 && (o == FRP_OP_RESET ? busy !== 1'b0 : rsp_valid !== 1'b1)) begin
      @(posedge clock); #1; n++;
    end
    chk1("handshake done", 1'b1, n < 500);
  endtask : op
  task automatic wr(input logic [22:0] ad, input logic [7:0] wd);
    op(FRP_OP_WRITE, ad, wd);
    if (!exp_prot[ad[22:17]] || req_temp_unprot) exp_mem[ad] = wd;
  endtask : wr
  task automatic rd(input logic [22:0] ad);
    op(FRP_OP_READ, ad, 8'h00);
    chk8("read data", exp_mem.exists(ad) ? exp_mem[ad] : 8'hff, rsp_rdata);
  endtask : rd
  task automatic ver(input logic [22:0] ad);
    op(FRP_OP_VERIFY, ad, 8'h00);
    chk1("protect flag", exp_prot[ad[22:17]], rsp_protected);
    chk8("verify byte", {7'h00, exp_prot[ad[22:17]]}, rsp_rdata);
  endtask : ver
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_n = 1;
    op(FRP_OP_ID_MFR, 23'h000000, 8'h00);
    chk1("reset pulse length", 1'b1, rlow >= RESET_PULSE_CYC);
    chk8("maker code", MFR, rsp_rdata);
    op(FRP_OP_ID_DEV, 23'h7fffff, 8'h00);
    chk8("device code", DEV, rsp_rdata);
    $display("id test done");
    repeat (6) begin
      a = 23'($random(seed));
      d = 8'($random(seed));
      wr(a, d);
      rd(a);
    end
    rd(23'h000000);
    $display("array test done");
    a = 23'($random(seed));
    d = 8'($random(seed));
    wr(a, d);
    op(FRP_OP_PROTECT, a, 8'h00);
    exp_prot[a[22:17]] = 1'b1;
    ver(a);
    ver(a ^ 23'h008000);
    ver(a ^ 23'h020000);
    wr(a, ~d);
    rd(a);
    req_temp_unprot = 1;
    wr(a, d ^ 8'h5a);
    rd(a);
    req_temp_unprot = 0;
    wr(a, 8'h00);
    rd(a);
    op(FRP_OP_UNPROT, a, 8'h00);
    exp_prot = '0;
    ver(a);
    ver(a ^ 23'h408000);
    $display("protect test done");
    wr(a, d);
    rlow0 = rlow;
    op(FRP_OP_RESET, a, 8'h00);
    chk1("reset op pulse", 1'b1, (rlow - rlow0) >= RESET_PULSE_CYC);
    chk1("busy released", 1'b1, ready_busy_n);
    wr(a, d ^ 8'h33);
    rd(a);
    $display("reset test done");
    results();
  end
endmodule : flash_reset_protect_id_port_test
